// File: common/branch_skip_defines.vh
// constants for the branch, skip and interrupt instruction decoder
// assumes 16-bit instruction words and a 32-bit AXI4-Lite register bus
`ifndef BRANCH_SKIP_DEFINES_VH
`define BRANCH_SKIP_DEFINES_VH

// instruction word fields
`define IC_HI 15
`define IC_LO 10
`define A_HI 9
`define A_LO 8
`define B_HI 7
`define B_LO 4
`define C_HI 3
`define C_LO 0

// opcode prefixes
`define OP_REG_MASK5 5'h08
`define OP_MEM_ONES5 5'h1a
`define OP_MEM_ZEROS5 5'h1b
`define OP_MISC6 6'h3f
`define OP_CALL3 3'h5
`define OP_JUMP2 2'h2

// low nibble of the miscellaneous group
`define C_SKIP_RET 4'h3
`define C_IRQ 4'h7

// A field codes
`define A_00 2'h0
`define A_01 2'h1
`define A_10 2'h2
`define A_11 2'h3

// sizes
`define PC_W 13
`define RET_DEPTH 16
`define RET_PTR_W 4
`define IRQ_DEPTH 4
`define IRQ_PTR_W 2
`define CTX_W 26
`define CTX_CARRY_BIT 25

// register offsets
`define REG_CTRL 4'h0
`define REG_STATUS 4'h4
`define REG_PC 4'h8
`define REG_LAST 4'hc

// control register fields and reset values
`define CTRL_RUN_BIT 0
`define CTRL_IMF_BIT 1
`define CTRL_RUN_RST 1'b1
`define IMF_RST 1'b0
`define PC_RST 13'h0000

// status register fields
`define ST_IMF_BIT 0
`define ST_SKIP_BIT 1
`define ST_RPTR_LO 4
`define ST_IPTR_LO 8

// bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// File: design/lifo_stack.v
// last-in first-out stack held in flip-flops
// assumes push and pop never arrive together; the pointer wraps on overflow
module lifo_stack #(
  parameter W = 13,
  parameter D = 16,
  parameter AW = 4
) (
  // clock, reset, enable
  input wire aclk,
  input wire aresetn,
  input wire ce,
  // stack operations
  input wire push,
  input wire pop,
  input wire [W-1:0] din,
  // top entry and fill pointer
  output wire [W-1:0] top,
  output reg [AW-1:0] ptr_q
);

  reg [W-1:0] mem_q [0:D-1]; // entries, index is slot number
  wire [AW-1:0] top_idx; // slot of the most recent push

  assign top_idx = ptr_q - {{(AW-1){1'b0}}, 1'b1};
  assign top = mem_q[top_idx];

  // pointer moves up on push, down on pop
  always @(posedge aclk)
  begin
    if (!aresetn)
      ptr_q <= {AW{1'b0}};
    else if (ce && push)
      ptr_q <= ptr_q + {{(AW-1){1'b0}}, 1'b1};
    else if (ce && pop)
      ptr_q <= top_idx;
  end

  // each slot loads only when the pointer names it
  genvar i;
  generate
    for (i = 0; i < D; i = i + 1)
    begin : g_slot
      always @(posedge aclk)
      begin
        if (!aresetn)
          mem_q[i] <= {W{1'b0}};
        else if (ce && push && (ptr_q == i))
          mem_q[i] <= din;
      end
    end
  endgenerate

endmodule // lifo_stack

// File: design/branch_skip_irq_decoder.v
// decode and execute of skip, call, return, jump and interrupt instructions
// assumes program and data memory, general registers and carry live on aclk
//
// Implementation choices: the register addresses and the AXI4-Lite interface to the registers.
`include "branch_skip_defines.vh"

module branch_skip_irq_decoder (
  // clock, reset, enable
  input wire aclk,
  input wire aresetn,
  input wire ce,
  // program memory
  input wire [15:0] instr_word,
  input wire instr_valid,
  output reg fetch_req_q,
  output reg [`PC_W-1:0] pc_q,
  // data memory and general registers
  input wire [3:0] mem_nibble,
  input wire [3:0] gen_reg,
  output reg [1:0] mem_row_field_q,
  output reg [3:0] mem_column_field_q,
  output reg [3:0] reg_sel_q,
  // carry and context
  input wire carry_flag,
  input wire [`CTX_W-1:0] ctx_save,
  output reg [`CTX_W-1:0] ctx_restore_q,
  output reg ctx_restore_stb_q,
  output reg carry_bit_q,
  // interrupt entry from the interrupt controller
  input wire irq_req,
  input wire [`PC_W-1:0] irq_vector,
  output reg irq_ack_q,
  output reg irq_master_flag_q,
  // words this block does not execute
  output reg [15:0] foreign_word_q,
  output reg foreign_stb_q,
  // axi4-lite write address
  input wire [31:0] awaddr,
  input wire awvalid,
  output reg awready_q,
  // axi4-lite write data
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output reg wready_q,
  // axi4-lite write response
  output reg [1:0] bresp_q,
  output reg bvalid_q,
  input wire bready,
  // axi4-lite read address
  input wire [31:0] araddr,
  input wire arvalid,
  output reg arready_q,
  // axi4-lite read data
  output reg [31:0] rdata_q,
  output reg [1:0] rresp_q,
  output reg rvalid_q,
  input wire rready
);

  // one-hot sequencer states
  localparam [2:0] ST_FETCH = 3'b001; // wait for a word
  localparam [2:0] ST_OPER = 3'b010; // memory operand settles
  localparam [2:0] ST_EXEC = 3'b100; // act on the word

  reg [2:0] state_q; // sequencer state
  reg [15:0] instr_q; // word under execution
  reg skip_q; // next word is to be suppressed
  reg run_q; // software run control
  reg [15:0] last_q; // last word through execute, suppressed or not, for software

  // stack control strobes
  reg ret_push; // push onto return address stack
  reg ret_pop; // pop return address stack
  reg irq_push; // push onto interrupt context stack
  reg irq_pop; // pop interrupt context stack
  reg [`PC_W-1:0] ret_din; // address to push
  wire [`PC_W-1:0] ret_top; // top of return address stack
  wire [`CTX_W-1:0] irq_top; // top of interrupt context stack
  wire [`RET_PTR_W-1:0] return_stack_ptr; // return stack fill
  wire [`IRQ_PTR_W-1:0] irq_stack_ptr; // interrupt stack fill

  // instruction fields
  wire [5:0] ic = instr_q[`IC_HI:`IC_LO];
  wire [1:0] fa = instr_q[`A_HI:`A_LO];
  wire [3:0] fc = instr_q[`C_HI:`C_LO];
  wire [`PC_W-1:0] pc_inc = pc_q + 13'h0001;

  // decode of this block's opcodes
  wire is_misc = (ic == `OP_MISC6);
  wire test_reg_mask_ones = (ic[5:1] == `OP_REG_MASK5) && !ic[0];
  wire test_reg_mask_zeros = (ic[5:1] == `OP_REG_MASK5) && ic[0];
  wire test_mem_ones = (ic[5:1] == `OP_MEM_ONES5) && ic[0];
  wire test_mem_zeros = (ic[5:1] == `OP_MEM_ZEROS5) && ic[0];
  wire test_mem_not_ones = (ic[5:1] == `OP_MEM_ONES5) && !ic[0];
  wire test_mem_not_zeros = (ic[5:1] == `OP_MEM_ZEROS5) && !ic[0];
  wire grp_sr = is_misc && (fc == `C_SKIP_RET);
  wire grp_irq = is_misc && (fc == `C_IRQ);
  wire skip_on_carry = grp_sr && (fa == `A_00);
  wire skip_on_no_carry = grp_sr && (fa == `A_01);
  wire subroutine_return = grp_sr && (fa == `A_10);
  wire return_then_skip = grp_sr && (fa == `A_11);
  wire irq_disable = grp_irq && (fa == `A_00);
  wire irq_enable = grp_irq && (fa == `A_01);
  wire irq_return = grp_irq && (fa == `A_11);
  wire is_call = (instr_q[15:13] == `OP_CALL3);
  wire is_jump = (instr_q[15:14] == `OP_JUMP2) && !is_call;

  // masked bits all one; an empty mask counts as all one
  function masked_ones;
    input [3:0] mask;
    input [3:0] val;
    begin
      masked_ones = ((val & mask) == mask);
    end
  endfunction

  // masked bits all zero
  function masked_zeros;
    input [3:0] mask;
    input [3:0] val;
    begin
      masked_zeros = ((val & mask) == 4'h0);
    end
  endfunction

  // skip decision for the word in execution
  reg skip_hit;
  always @*
  begin
    skip_hit = 1'b0;
    if (test_reg_mask_ones)
      skip_hit = masked_ones(mem_nibble, gen_reg);
    else if (test_reg_mask_zeros)
      skip_hit = masked_zeros(mem_nibble, gen_reg);
    else if (test_mem_ones)
      skip_hit = masked_ones(fc, mem_nibble);
    else if (test_mem_zeros)
      skip_hit = masked_zeros(fc, mem_nibble);
    else if (test_mem_not_ones)
      skip_hit = !masked_ones(fc, mem_nibble);
    else if (test_mem_not_zeros)
      skip_hit = !masked_zeros(fc, mem_nibble);
    else if (skip_on_carry)
      skip_hit = carry_flag;
    else if (skip_on_no_carry)
      skip_hit = !carry_flag;
    else if (return_then_skip)
      skip_hit = 1'b1;
  end

  wire exec_now = (state_q == ST_EXEC) && !skip_q; // real execution cycle
  wire irq_take = (state_q == ST_FETCH) && run_q && irq_req && irq_master_flag_q
                  && !skip_q; // a pending skip must land on the next program word

  // stack strobes; a suppressed word never touches a stack
  always @*
  begin
    ret_push = 1'b0;
    ret_pop = 1'b0;
    irq_push = 1'b0;
    irq_pop = 1'b0;
    ret_din = pc_inc;
    if (irq_take)
    begin
      ret_push = 1'b1; // resume address for the interrupt return
      irq_push = 1'b1;
      ret_din = pc_q;
    end
    else if (exec_now)
    begin
      ret_push = is_call;
      ret_pop = subroutine_return || return_then_skip || irq_return;
      irq_pop = irq_return;
    end
  end

  // return address stack
  lifo_stack #(
    .W(`PC_W),
    .D(`RET_DEPTH),
    .AW(`RET_PTR_W)
  ) u_ret_stack (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .push(ret_push),
    .pop(ret_pop),
    .din(ret_din),
    .top(ret_top),
    .ptr_q(return_stack_ptr)
  );

  // interrupt context stack
  lifo_stack #(
    .W(`CTX_W),
    .D(`IRQ_DEPTH),
    .AW(`IRQ_PTR_W)
  ) u_irq_stack (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .push(irq_push),
    .pop(irq_pop),
    .din(ctx_save),
    .top(irq_top),
    .ptr_q(irq_stack_ptr)
  );

  // software side strobes
  reg sw_wr; // write committed this cycle
  reg [3:0] sw_addr; // byte offset of that write
  reg [31:0] aw_addr_q; // held write address
  reg aw_ok_q; // write address held
  reg [31:0] w_data_q; // held write data
  reg [3:0] w_strb_q; // held byte enables
  reg w_ok_q; // write data held
  wire ctrl_wr = sw_wr && (sw_addr == `REG_CTRL) && w_strb_q[0];

  // sequencer, program counter and execution
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q <= ST_FETCH;
      instr_q <= 16'h0000;
      skip_q <= 1'b0;
      pc_q <= `PC_RST;
      fetch_req_q <= 1'b0;
      mem_row_field_q <= 2'h0;
      mem_column_field_q <= 4'h0;
      reg_sel_q <= 4'h0;
      ctx_restore_q <= {`CTX_W{1'b0}};
      ctx_restore_stb_q <= 1'b0;
      carry_bit_q <= 1'b0;
      irq_ack_q <= 1'b0;
      irq_master_flag_q <= `IMF_RST;
      foreign_word_q <= 16'h0000;
      foreign_stb_q <= 1'b0;
      last_q <= 16'h0000;
    end
    else if (ce)
    begin
      // pulses last one cycle
      ctx_restore_stb_q <= 1'b0;
      irq_ack_q <= 1'b0;
      foreign_stb_q <= 1'b0;
      // software write of the master flag; an instruction below wins
      if (ctrl_wr)
        irq_master_flag_q <= w_data_q[`CTRL_IMF_BIT];
      case (state_q)
        ST_FETCH:
        begin
          fetch_req_q <= run_q && !irq_take;
          if (irq_take)
          begin
            // entry: context saved, vector loaded, nesting blocked
            pc_q <= irq_vector;
            irq_master_flag_q <= 1'b0;
            irq_ack_q <= 1'b1;
          end
          else if (run_q && fetch_req_q && instr_valid)
          begin
            instr_q <= instr_word;
            mem_row_field_q <= instr_word[`A_HI:`A_LO];
            mem_column_field_q <= instr_word[`B_HI:`B_LO];
            reg_sel_q <= instr_word[`C_HI:`C_LO];
            fetch_req_q <= 1'b0;
            state_q <= ST_OPER;
          end
        end
        ST_OPER:
        begin
          // data memory and register answer to the held fields
          state_q <= ST_EXEC;
        end
        ST_EXEC:
        begin
          state_q <= ST_FETCH;
          fetch_req_q <= run_q;
          last_q <= instr_q;
          if (skip_q)
          begin
            // suppressed word: only the count and last_q change
            skip_q <= 1'b0;
            pc_q <= pc_inc;
          end
          else if (is_call)
            pc_q <= instr_q[`PC_W-1:0];
          else if (is_jump)
            pc_q <= instr_q[`PC_W-1:0];
          else if (subroutine_return)
            pc_q <= ret_top;
          else if (return_then_skip)
          begin
            pc_q <= ret_top;
            skip_q <= 1'b1;
          end
          else if (irq_return)
          begin
            // interrupted word is re-fetched at the saved address
            pc_q <= ret_top;
            ctx_restore_q <= irq_top;
            carry_bit_q <= irq_top[`CTX_CARRY_BIT];
            ctx_restore_stb_q <= 1'b1;
            irq_master_flag_q <= 1'b1;
          end
          else
          begin
            pc_q <= pc_inc;
            skip_q <= skip_hit;
            if (irq_disable)
              irq_master_flag_q <= 1'b0;
            else if (irq_enable)
              irq_master_flag_q <= 1'b1;
            else if (!(grp_sr || grp_irq || test_reg_mask_ones || test_reg_mask_zeros
                       || test_mem_ones || test_mem_zeros || test_mem_not_ones
                       || test_mem_not_zeros))
            begin
              // handed to the rest of the core
              foreign_word_q <= instr_q;
              foreign_stb_q <= 1'b1;
            end
          end
        end
        default:
        begin
          state_q <= ST_FETCH;
        end
      endcase
    end
  end

  // register read mux; unmapped offsets flagged by the caller
  function [31:0] reg_read;
    input [3:0] off;
    begin
      case (off)
        `REG_CTRL: reg_read = {30'h0, irq_master_flag_q, run_q};
        `REG_STATUS: reg_read = {22'h0, irq_stack_ptr, return_stack_ptr, 2'h0,
                                 skip_q, irq_master_flag_q};
        `REG_PC: reg_read = {19'h0, pc_q};
        `REG_LAST: reg_read = {16'h0, last_q};
        default: reg_read = 32'h0;
      endcase
    end
  endfunction

  // only the four aligned words in the first sixteen bytes exist
  function mapped;
    input [31:0] a;
    begin
      mapped = (a[31:4] == 28'h0) && (a[1:0] == 2'h0);
    end
  endfunction

  always @*
  begin
    sw_wr = aw_ok_q && w_ok_q && !bvalid_q && mapped(aw_addr_q);
    sw_addr = aw_addr_q[3:0];
  end

  // axi4-lite slave; address and data may come in either order
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= `RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rresp_q <= `RESP_OKAY;
      rdata_q <= 32'h0;
      aw_ok_q <= 1'b0;
      aw_addr_q <= 32'h0;
      w_ok_q <= 1'b0;
      w_data_q <= 32'h0;
      w_strb_q <= 4'h0;
      run_q <= `CTRL_RUN_RST;
    end
    else if (ce)
    begin
      // ready pulses one cycle per held item
      awready_q <= awvalid && !awready_q && !aw_ok_q && !bvalid_q;
      wready_q <= wvalid && !wready_q && !w_ok_q && !bvalid_q;
      if (awvalid && awready_q)
      begin
        aw_ok_q <= 1'b1;
        aw_addr_q <= awaddr;
      end
      if (wvalid && wready_q)
      begin
        w_ok_q <= 1'b1;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
      // response once both halves are held
      if (aw_ok_q && w_ok_q && !bvalid_q)
      begin
        bvalid_q <= 1'b1;
        bresp_q <= mapped(aw_addr_q) ? `RESP_OKAY : `RESP_SLVERR;
        aw_ok_q <= 1'b0;
        w_ok_q <= 1'b0;
      end
      else if (bvalid_q && bready)
        bvalid_q <= 1'b0;
      if (ctrl_wr)
        run_q <= w_data_q[`CTRL_RUN_BIT];
      // reads answer the cycle after the address is taken
      arready_q <= arvalid && !arready_q && !rvalid_q;
      if (arvalid && arready_q)
      begin
        rvalid_q <= 1'b1;
        rdata_q <= mapped(araddr) ? reg_read(araddr[3:0]) : 32'h0;
        rresp_q <= mapped(araddr) ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (rvalid_q && rready)
        rvalid_q <= 1'b0;
    end
  end

endmodule // branch_skip_irq_decoder

// File: verif/decoder_sva.sv
// assertions for the skip, call, return, jump and interrupt decoder
// assumes one aclk domain; sees only the decoder's ports through bind
`include "branch_skip_defines.vh"
module decoder_sva (
  // clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // program side
  input wire logic [15:0] instr_word,
  input wire logic instr_valid,
  input wire logic fetch_req_q,
  input wire logic [`PC_W-1:0] pc_q,
  input wire logic [3:0] mem_nibble,
  input wire logic [3:0] gen_reg,
  input wire logic carry_flag,
  // context and interrupt
  input wire logic [`CTX_W-1:0] ctx_restore_q,
  input wire logic ctx_restore_stb_q,
  input wire logic carry_bit_q,
  input wire logic irq_ack_q,
  input wire logic irq_master_flag_q
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  wire take = fetch_req_q & instr_valid & ce; // word accepted this edge
  logic [1:0] t_q; // take delayed; bit 1 marks the execute edge
  logic [15:0] w_q; // word under execution
  logic skp_q; // next word is to be dropped
  logic cond; // skip condition seen at the execute edge
  wire ex = t_q[1] & ce;
  wire live = ex & !skp_q; // word really executes
  wire misc = w_q[15:10] == 6'h3f;
  wire [3:0] m = w_q[3:0];
  // skip conditions; operands are valid only at the execute edge
  always_comb
  begin
    cond = 1'b0;
    if (w_q[15:11] == 5'h08) // memory nibble masks the register
      cond = w_q[10] ? (gen_reg & mem_nibble) == 4'h0 : (gen_reg & mem_nibble) == mem_nibble;
    else if (w_q[15:11] == 5'h1a) // ones test, bit 10 low negates
      cond = w_q[10] ~^ ((mem_nibble & m) == m);
    else if (w_q[15:11] == 5'h1b) // zeros test, bit 10 low negates
      cond = w_q[10] ~^ ((mem_nibble & m) == 4'h0);
    else if (misc && m == 4'h3) // carry skips, return then skip
      cond = w_q[9:8] == 2'h0 ? carry_flag : w_q[9:8] == 2'h1 ? !carry_flag : &w_q[9:8];
  end
  // helper state; a skipped word never raises a skip of its own
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      t_q <= 2'h0;
      w_q <= 16'h0;
      skp_q <= 1'b0;
    end
    else if (ce)
    begin
      t_q <= {t_q[0], take};
      if (take)
        w_q <= instr_word;
      if (ex)
        skp_q <= !skp_q && cond;
    end
  end
  skip_drop_a: assert property (ex && skp_q |=> pc_q == $past(pc_q) + 1'b1)
    else $error("skipped word did not just advance pc");
  jump_load_a: assert property (live && w_q[15:13] == 3'h4 |=> pc_q == $past(w_q[12:0]))
    else $error("jump target not loaded");
  call_load_a: assert property (live && w_q[15:13] == 3'h5 |=> pc_q == $past(w_q[12:0]))
    else $error("call target not loaded");
  flag_set_a: assert property (live && misc && m == 4'h7 && w_q[8] |=> irq_master_flag_q)
    else $error("master flag not set");
  flag_clr_a: assert property (live && misc && m == 4'h7 && w_q[9:8] == 2'h0 |=>
    !irq_master_flag_q)
    else $error("master flag not cleared");
  ctx_pop_a: assert property (live && misc && m == 4'h7 && &w_q[9:8] |=>
    ctx_restore_stb_q && carry_bit_q == ctx_restore_q[`CTX_CARRY_BIT])
    else $error("context not restored");
  fetch_seq_a: assert property (take |=> !fetch_req_q ##1 !fetch_req_q ##1 fetch_req_q)
    else $error("fetch spacing wrong");
  ack_pulse_a: assert property (irq_ack_q |-> !irq_master_flag_q ##1 !irq_ack_q)
    else $error("entry pulse wrong");
  // main scenarios
  cover property (ex && skp_q);
  cover property (irq_ack_q);
  cover property (ctx_restore_stb_q);
endmodule // decoder_sva

bind branch_skip_irq_decoder decoder_sva u_sva (.aclk, .aresetn, .ce, .instr_word, .instr_valid,
  .fetch_req_q, .pc_q, .mem_nibble, .gen_reg, .carry_flag, .ctx_restore_q, .ctx_restore_stb_q,
  .carry_bit_q, .irq_ack_q, .irq_master_flag_q);

// File: verif/branch_skip_irq_decoder_tb.sv
// self-checking bench for the skip, call, return, jump and interrupt decoder
// assumes the decoder's hand-over timing; ce held high throughout
`include "branch_skip_defines.vh"
module branch_skip_irq_decoder_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk, aresetn, instr_valid, carry_flag, irq_req, awvalid, wvalid, bready, arvalid, rready;
  logic [15:0] instr_word;
  logic [3:0] mem_nibble, gen_reg;
  logic [`PC_W-1:0] irq_vector, exp_pc;
  logic [`CTX_W-1:0] ctx_save;
  logic [31:0] awaddr, wdata, araddr, rd_data;
  logic [1:0] rd_resp;
  wire fetch_req_q, ctx_restore_stb_q, carry_bit_q, irq_ack_q, irq_master_flag_q, foreign_stb_q;
  wire awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  wire [`PC_W-1:0] pc_q;
  wire [1:0] mem_row_field_q, bresp_q, rresp_q;
  wire [3:0] mem_column_field_q, reg_sel_q;
  wire [`CTX_W-1:0] ctx_restore_q;
  wire [15:0] foreign_word_q;
  wire [31:0] rdata_q;
  int mismatches, checked;
  // rows: word, memory nibble, general register, carry, skip expected
  logic [25:0] rows [16] = '{
    {16'hd403, 4'h3, 4'h0, 2'h1}, {16'hd403, 4'h1, 4'h0, 2'h0},
    {16'hdc03, 4'h4, 4'h0, 2'h1}, {16'hdc03, 4'h2, 4'h0, 2'h0},
    {16'hd003, 4'h1, 4'h0, 2'h1}, {16'hd003, 4'h7, 4'h0, 2'h0},
    {16'hd803, 4'h2, 4'h0, 2'h1}, {16'hd803, 4'hc, 4'h0, 2'h0},
    {16'h4000, 4'h5, 4'hf, 2'h1}, {16'h4000, 4'h5, 4'h4, 2'h0},
    {16'h4400, 4'h5, 4'ha, 2'h1}, {16'h4400, 4'h5, 4'h1, 2'h0},
    {16'hfc03, 4'h0, 4'h0, 2'h3}, {16'hfc03, 4'h0, 4'h0, 2'h0},
    {16'hfd03, 4'h0, 4'h0, 2'h1}, {16'hfd03, 4'h0, 4'h0, 2'h2}};
  branch_skip_irq_decoder u_dut (.aclk, .aresetn, .ce(1'b1), .instr_word, .instr_valid,
    .fetch_req_q, .pc_q, .mem_nibble, .gen_reg, .mem_row_field_q, .mem_column_field_q, .reg_sel_q,
    .carry_flag, .ctx_save, .ctx_restore_q, .ctx_restore_stb_q, .carry_bit_q, .irq_req,
    .irq_vector, .irq_ack_q, .irq_master_flag_q, .foreign_word_q, .foreign_stb_q, .awaddr,
    .awvalid, .awready_q, .wdata, .wstrb(4'hf), .wvalid, .wready_q, .bresp_q, .bvalid_q, .bready,
    .araddr, .arvalid, .arready_q, .rdata_q, .rresp_q, .rvalid_q, .rready);
  // 100 ns clock
  initial
  begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one word: wait for fetch, offer it, hold operands through the execute edge
  task automatic exec(input logic [15:0] w, input logic [3:0] nib, gr, input logic cy);
    // no limit here: only the watchdog ends a wait
    do
    begin
      @(posedge aclk);
    end
    while (fetch_req_q !== 1'b1);
    instr_word <= w;
    instr_valid <= 1'b1;
    mem_nibble <= nib;
    gen_reg <= gr;
    carry_flag <= cy;
    @(posedge aclk);
    instr_valid <= 1'b0;
    repeat (2) @(posedge aclk);
    #1;
  endtask
  // bus write: both halves offered together, each released when taken
  task automatic wr(input logic [31:0] a, d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready_q === 1'b1)
        awvalid <= 1'b0;
      if (wready_q === 1'b1)
        wvalid <= 1'b0;
    end
    while (bvalid_q !== 1'b1);
    bready <= 1'b0;
    rd_resp = bresp_q;
  endtask
  task automatic rd(input logic [31:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready_q === 1'b1)
        arvalid <= 1'b0;
    end
    while (rvalid_q !== 1'b1);
    rready <= 1'b0;
    rd_data = rdata_q;
    rd_resp = rresp_q;
  endtask
  task automatic summarize();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // watchdog, far beyond the roughly 220 cycles the tests need
  initial
  begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    $display("[ERR] %0t watchdog expired", $time);
    summarize();
  end
  // main sequence
  initial
  begin
    {aresetn, instr_valid, carry_flag, irq_req, awvalid, wvalid, bready, arvalid, rready} = 9'h0;
    {instr_word, mem_nibble, gen_reg, irq_vector, ctx_save} = 63'h0;
    {awaddr, wdata, araddr} = 96'h0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    #1;
    chk(32'(pc_q), 32'h0);
    chk(32'(irq_master_flag_q), 32'h0);
    exp_pc = 13'h0;
    $display("reset test done");
    for (int i = 0; i < 16; i++)
    begin
      exec(rows[i][25:10], rows[i][9:6], rows[i][5:2], rows[i][1]);
      exp_pc = exp_pc + 1'b1;
      chk(32'(pc_q), 32'(exp_pc));
      exec({3'h4, 13'h1f00 | 13'(i)}, 4'h0, 4'h0, 1'b0);
      exp_pc = rows[i][0] ? exp_pc + 1'b1 : 13'h1f00 | 13'(i);
      chk(32'(pc_q), 32'(exp_pc));
    end
    $display("table test done");
    exec(16'hac00, 4'h0, 4'h0, 1'b0);
    chk(32'(pc_q), 32'h0c00);
    exec(16'hb234, 4'h0, 4'h0, 1'b0);
    chk(32'(pc_q), 32'h1234);
    chk(32'({mem_row_field_q, mem_column_field_q, reg_sel_q}), 32'h234);
    exec(16'hfe03, 4'h0, 4'h0, 1'b0);
    chk(32'(pc_q), 32'h0c01);
    exec(16'hff03, 4'h0, 4'h0, 1'b0);
    chk(32'(pc_q), 32'(exp_pc + 1'b1));
    exec(16'h8100, 4'h0, 4'h0, 1'b0);
    exp_pc = exp_pc + 2'h2;
    chk(32'(pc_q), 32'(exp_pc));
    $display("subroutine test done");
    exec(16'hfd07, 4'h0, 4'h0, 1'b0);
    chk(32'(irq_master_flag_q), 32'h1);
    exec(16'hfc07, 4'h0, 4'h0, 1'b0);
    chk(32'(irq_master_flag_q), 32'h0);
    exec(16'hfd07, 4'h0, 4'h0, 1'b0);
    exp_pc = exp_pc + 2'h3;
    @(posedge aclk);
    irq_vector <= 13'h0700;
    ctx_save <= 26'h2abcdef;
    irq_req <= 1'b1;
    do
    begin
      @(posedge aclk);
    end
    while (irq_ack_q !== 1'b1);
    irq_req <= 1'b0;
    #1;
    chk(32'(pc_q), 32'h0700);
    exec(16'hff07, 4'h0, 4'h0, 1'b0);
    chk(32'(pc_q), 32'(exp_pc));
    chk(32'(irq_master_flag_q), 32'h1);
    chk(32'(ctx_restore_stb_q), 32'h1);
    chk(32'(ctx_restore_q), 32'h2abcdef);
    chk(32'(carry_bit_q), 32'h1);
    $display("interrupt test done");
    rd(32'h4);
    chk(rd_data & 32'h3f3, 32'h1);
    rd(32'h8);
    chk(rd_data, 32'(exp_pc));
    rd(32'h20);
    chk(32'(rd_resp), 32'(`RESP_SLVERR));
    chk(rd_data, 32'h0);
    wr(32'h0, 32'h1);
    chk(32'(rd_resp), 32'(`RESP_OKAY));
    chk(32'(irq_master_flag_q), 32'h0);
    rd(32'h0);
    chk(rd_data, 32'h1);
    wr(32'h14, 32'h3);
    chk(32'(rd_resp), 32'(`RESP_SLVERR));
    chk(32'(irq_master_flag_q), 32'h0);
    $display("register bus test done");
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    #1;
    chk(32'(pc_q), 32'h0);
    exec(16'h8123, 4'h0, 4'h0, 1'b0);
    chk(32'(pc_q), 32'h0123);
    exec(16'h5123, 4'h0, 4'h0, 1'b0);
    chk(32'(foreign_stb_q), 32'h1);
    chk(32'(foreign_word_q), 32'h5123);
    chk(32'(pc_q), 32'h0124);
    rd(32'hc);
    chk(rd_data, 32'h5123);
    $display("second reset test done");
    summarize();
  end
endmodule // branch_skip_irq_decoder_tb
